// ===== bench/wit_asserts.sv
`timescale 1ns/1ns
`default_nettype none
`include "wit_map.vh"
module wit_asserts (
    // Clock and reset
    input wire logic        clk,
    input wire logic        reset_n,
    // Register access
    input wire logic        reg_sel,
    input wire logic        reg_wr,
    input wire logic [31:0] reg_addr,
    input wire logic [1:0]  reg_size,
    input wire logic [15:0] reg_wdata,
    input wire logic [7:0]  reg_rdata,
    // Standby and events
    input wire logic        standby_active,
    input wire logic        standby_wake,
    input wire logic        freq_change,
    input wire logic        clock_resume,
    input wire logic        por_req,
    input wire logic        manual_req,
    input wire logic        interval_irq,
    // Clock output pin
    input wire logic        clock_output_enable,
    input wire logic        sys_clk_level,
    input wire logic        clock_output_pin_o,
    input wire logic        clock_output_pin_oe
);
    logic [2:0] ctl_q;
    logic       brd;
    logic       evt;
    assign brd = reg_sel && !reg_wr && reg_size == `WIT_SIZE_BYTE;
    assign evt = interval_irq || por_req || manual_req;
    // Run, mode and reset select change only by keyed software writes
    always @(posedge clk) begin
        if (!reset_n)
            ctl_q <= 3'h0;
        else if (reg_sel && reg_wr && reg_size == `WIT_SIZE_WORD && reg_addr == `WIT_ADDR_CTRL
                 && reg_wdata[15:8] == `WIT_KEY_CTRL)
            ctl_q <= reg_wdata[7:5];
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    pin_drive_a: assert property (clock_output_pin_o == sys_clk_level) else $error("pin level");
    pin_enable_a: assert property (clock_output_pin_oe == clock_output_enable) else $error("pin enable");
    reset_clear_a: assert property (disable iff (1'b0) !reset_n |=> !(evt || clock_resume)
        && reg_rdata == 8'h00) else $error("reset outputs");
    event_single_a: assert property (evt |=> !evt [*8]) else $error("event repeat");
    event_excl_a: assert property ($onehot0({evt, clock_resume})) else $error("event clash");
    irq_mode_a: assert property (interval_irq |-> ctl_q[2] && !ctl_q[1]) else $error("irq mode");
    por_mode_a: assert property (por_req |-> ctl_q == 3'b110) else $error("por mode");
    manual_mode_a: assert property (manual_req |-> ctl_q == 3'b111) else $error("manual mode");
    rdata_hold_a: assert property (!brd |=> $stable(reg_rdata)) else $error("rdata moved");
    unmapped_read_a: assert property (brd && reg_addr != `WIT_ADDR_COUNT && reg_addr != `WIT_ADDR_CTRL
        |=> reg_rdata == 8'h00) else $error("unmapped read");
    irq_c: cover property (interval_irq);
    manual_c: cover property (manual_req);
    resume_c: cover property (clock_resume);
endmodule
`default_nettype wire

// ===== bench/wit_far_model.sv
`timescale 1ns/1ns
`default_nettype none
module wit_far_model (
    // Clock and timer events: irq, power-on, manual, resume
    input wire logic        clk,
    input wire logic [3:0]  ev,
    // System clock and event tallies
    output logic            sys_clk_level,
    output logic [3:0][7:0] tally
);
    initial begin
        sys_clk_level = 1'b0;
        tally = '0;
    end
    // Interrupt controller, reset logic and clock generator each take every pulse
    always @(posedge clk) begin
        sys_clk_level <= ~sys_clk_level;
        for (int i = 0; i < 4; i++)
            if (ev[i]) tally[i] <= tally[i] + 8'h01;
    end
endmodule
`default_nettype wire

// ===== bench/wit_top_bench.sv
`timescale 1ns/1ns
`default_nettype none
`include "wit_map.vh"
module wit_top_bench;
    logic            clk, reset_n, reg_sel, reg_wr, standby_active, standby_wake, freq_change, clock_output_enable;
    logic [31:0]     reg_addr;
    logic [1:0]      reg_size;
    logic [15:0]     reg_wdata;
    wire  [7:0]      reg_rdata;
    wire             clock_resume, por_req, manual_req, interval_irq, sys_clk_level;
    wire             clock_output_pin_o, clock_output_pin_oe;
    wire  [3:0]      evs = {clock_resume, manual_req, por_req, interval_irq};
    wire  [3:0][7:0] tally;
    int              failures, cmp_count, cyc, c;
    wit_top DUT (.clk, .reset_n, .reg_sel, .reg_wr, .reg_addr, .reg_size, .reg_wdata, .reg_rdata, .standby_active,
        .standby_wake, .freq_change, .clock_resume, .por_req, .manual_req, .interval_irq, .clock_output_enable,
        .sys_clk_level, .clock_output_pin_o, .clock_output_pin_oe);
    wit_far_model FAR (.clk, .ev(evs), .sys_clk_level, .tally);
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            failures++;
            stop_test;
        end
    end
    task stop_test;
        $display("compares %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task chk(input string nm, input logic [7:0] s, input logic [7:0] e);
        cmp_count++;
        if (s !== e) begin
            failures++;
            $display("MISMATCH %s exp %h seen %h", nm, e, s);
        end
    endtask
    task acc(input logic [31:0] a, input logic w, input logic [1:0] sz, input logic [15:0] d);
        @(negedge clk);
        {reg_sel, reg_wr, reg_addr, reg_size, reg_wdata} = {1'b1, w, a, sz, d};
        @(negedge clk);
        reg_sel = 1'b0;
    endtask
    task rd(input logic [31:0] a, input logic [7:0] e, input string nm);
        acc(a, 1'b0, `WIT_SIZE_BYTE, 16'h0000);
        chk(nm, reg_rdata, e);
    endtask
    task wcnt(input logic [7:0] d);
        acc(`WIT_ADDR_COUNT, 1'b1, `WIT_SIZE_WORD, {`WIT_KEY_COUNT, d});
    endtask
    task wctl(input logic [7:0] d);
        acc(`WIT_ADDR_CTRL, 1'b1, `WIT_SIZE_WORD, {`WIT_KEY_CTRL, d});
    endtask
    task wt(input int k, input int lim);
        c = 0;
        while (evs[k] !== 1'b1 && c < lim) begin
            @(negedge clk);
            c++;
        end
        chk("event_due", {7'h00, c < lim}, 8'h01);
    endtask
    initial begin
        {reset_n, reg_sel, reg_wr, reg_addr, reg_size, reg_wdata} = '0;
        {standby_active, standby_wake, freq_change, clock_output_enable} = 4'b0001;
        repeat (4) @(negedge clk);
        reset_n = 1'b1;
        rd(`WIT_ADDR_COUNT, 8'h00, "count_rst");
        rd(`WIT_ADDR_CTRL, 8'h00, "ctrl_rst");
        chk("pin_oe", {7'h00, clock_output_pin_oe}, 8'h01);
        clock_output_enable = 1'b0;
        #1 chk("pin_off", {7'h00, clock_output_pin_oe}, 8'h00);
        $display("test reset done");
        wcnt(8'h3C);
        rd(`WIT_ADDR_COUNT, 8'h3C, "count_key");
        acc(`WIT_ADDR_COUNT, 1'b1, `WIT_SIZE_WORD, 16'hA577);
        acc(`WIT_ADDR_COUNT, 1'b1, `WIT_SIZE_BYTE, 16'h5A77);
        acc(`WIT_ADDR_COUNT, 1'b1, `WIT_SIZE_LONG, 16'h5A77);
        rd(`WIT_ADDR_COUNT, 8'h3C, "count_nokey");
        acc(`WIT_ADDR_CTRL, 1'b1, `WIT_SIZE_WORD, 16'h5A85);
        acc(`WIT_ADDR_CTRL, 1'b1, `WIT_SIZE_BYTE, 16'hA585);
        rd(`WIT_ADDR_CTRL, 8'h00, "ctrl_nokey");
        wctl(8'h05);
        repeat (80) @(negedge clk);
        rd(`WIT_ADDR_COUNT, 8'h3C, "count_held");
        acc(`WIT_ADDR_CTRL, 1'b0, `WIT_SIZE_WORD, 16'h0000);
        chk("rdata_word", reg_rdata, 8'h3C);
        rd(32'hFFC00010, 8'h00, "unmapped");
        $display("test access done");
        for (int n = 0; n < 9; n++) begin
            wctl(8'h00);
            wcnt(8'hFF);
            wctl({5'h10, n[2:0]});
            wt(0, (32 << n[2:0]) + 8);
            chk("tick_gap", {7'h00, c > (16 << n[2:0]) && c <= (32 << n[2:0]) + 4}, 8'h01);
            rd(`WIT_ADDR_CTRL, {5'h11, n[2:0]}, "int_flag");
        end
        rd(`WIT_ADDR_COUNT, 8'h00, "wrap");
        repeat (40) @(negedge clk);
        rd(`WIT_ADDR_COUNT, 8'h01, "irq_keeps");
        $display("test interval done");
        for (int r = 0; r < 2; r++) begin
            wctl(8'h00);
            wcnt(8'hFF);
            wctl({2'b11, r[0], 5'h00});
            wt(1 + r, 80);
            rd(`WIT_ADDR_CTRL, {2'b11, r[0], 5'h10}, "wdog_flag");
            repeat (40) @(negedge clk);
            rd(`WIT_ADDR_COUNT, 8'h01, "wd_keeps");
        end
        wctl(8'h00);
        wcnt(8'h00);
        wctl(8'hC0);
        repeat (6) begin
            repeat (200) @(negedge clk);
            wcnt(8'h00);
        end
        rd(`WIT_ADDR_CTRL, 8'hC0, "wd_refreshed");
        $display("test watchdog done");
        for (int s = 0; s < 2; s++) begin
            wctl(8'h00);
            wcnt(8'hFE);
            standby_active = s[0];
            @(negedge clk);
            {standby_wake, freq_change} = {s[0], !s[0]};
            @(negedge clk);
            {standby_wake, freq_change} = 2'b00;
            wt(3, 100);
            standby_active = 1'b0;
            repeat (100) @(negedge clk);
            rd(`WIT_ADDR_COUNT, 8'h00, "stab_stop");
            rd(`WIT_ADDR_CTRL, 8'h00, "stab_flag");
        end
        chk("irq_n", tally[0], 8'h09);
        chk("por_n", tally[1], 8'h01);
        chk("man_n", tally[2], 8'h01);
        chk("res_n", tally[3], 8'h02);
        $display("test standby done");
        stop_test;
    end
endmodule
bind wit_top wit_asserts u_chk (.clk, .reset_n, .reg_sel, .reg_wr, .reg_addr, .reg_size, .reg_wdata, .reg_rdata,
    .standby_active, .standby_wake, .freq_change, .clock_resume, .por_req, .manual_req, .interval_irq,
    .clock_output_enable, .sys_clk_level, .clock_output_pin_o, .clock_output_pin_oe);
`default_nettype wire

// ===== inc/wit_map.vh
`ifndef WIT_MAP_VH
`define WIT_MAP_VH

// Register byte addresses
`define WIT_ADDR_COUNT      32'hFFC00008
`define WIT_ADDR_CTRL       32'hFFC0000C

// Write keys carried in the upper byte of a word write
`define WIT_KEY_COUNT       8'h5A
`define WIT_KEY_CTRL        8'hA5

// Access size codes
`define WIT_SIZE_BYTE       2'h0
`define WIT_SIZE_WORD       2'h1
`define WIT_SIZE_LONG       2'h2

// Control/status field positions
`define WIT_BIT_RUN         7
`define WIT_BIT_MODE        6
`define WIT_BIT_RSEL        5
`define WIT_BIT_WDOG_FLAG   4
`define WIT_BIT_INT_FLAG    3
`define WIT_SEL_HI          2
`define WIT_SEL_LO          0

// Reset values
`define WIT_RST_COUNT       8'h00
`define WIT_RST_CTRL        8'h00
`define WIT_RST_CLKOUT_EN   1'b1

// Prescaler width: largest division is 1/4096
`define WIT_PRE_W           12
`define WIT_DIV_MIN_LOG2    5

`endif

// ===== rtl/wit_counter.v
`timescale 1ns/1ns
`default_nettype none
`include "wit_map.vh"

module wit_counter (
    // Clock and power-on reset
    input  wire             clk,
    input  wire             por_n,
    // Control
    input  wire             tick,
    input  wire             load,
    input  wire [7:0]       load_value,
    input  wire             stop_zero,
    // State
    output reg  [7:0]       count_q,
    output wire             overflow
);

    assign overflow = tick && (count_q == 8'hFF); // R24

    always @(posedge clk) begin
        if (!por_n) begin
            count_q <= `WIT_RST_COUNT; // R2
        end else if (load) begin
            count_q <= load_value; // R4
        end else if (stop_zero) begin
            count_q <= count_q;
        end else if (tick) begin
            count_q <= count_q + 8'h01; // R1
        end
    end

endmodule
`default_nettype wire

// ===== rtl/wit_prescaler.v
`timescale 1ns/1ns
`default_nettype none
`include "wit_map.vh"

module wit_prescaler #(
    parameter PRE_W = `WIT_PRE_W
) (
    // Clock and reset
    input  wire             clk,
    input  wire             reset_n,
    // Control
    input  wire             run,
    input  wire [2:0]       clock_select_bits,
    // Count tick, one cycle
    output reg              tick
);

    reg [PRE_W-1:0] div_q;
    wire [PRE_W-1:0] div_d;
    wire [PRE_W-1:0] tap_sel;

    // Ones in the low (5 + select) bits, so the tick repeats every 2^(5 + select) clocks
    function [PRE_W-1:0] tap_mask;
        input [2:0] sel;
        begin
            tap_mask = {PRE_W{1'b1}} >> (PRE_W - `WIT_DIV_MIN_LOG2 - sel);
        end
    endfunction

    assign tap_sel = tap_mask(clock_select_bits);
    assign div_d = run ? div_q + {{(PRE_W-1){1'b0}}, 1'b1} : {PRE_W{1'b0}};

    // Tick fires when all bits below the selected tap wrap to zero
    always @(posedge clk) begin
        if (!reset_n) begin
            div_q <= {PRE_W{1'b0}};
            tick  <= 1'b0;
        end else begin
            div_q <= div_d;
            tick  <= run && ((div_q & tap_sel) == tap_sel); // R12
        end
    end

endmodule
`default_nettype wire

// ===== rtl/wit_top.v
// Function
// R1 - Eight-bit up-counter on prescaled clock; overflow gives reset or interrupt by mode.
// R2 - Counter and control clear to zero only on pin power-on reset.
// R3 - Control keeps value through watchdog reset and after standby stabilisation overflow.
// R4 - Word write with key 5A loads lower byte into the counter.
// R5 - Word write with key A5 loads lower byte into the control register.
// R6 - Byte reads only; byte and long writes ignored; only keyed word writes update.
// R7 - Run bit zero holds the counter; one lets it count up.
// R8 - Mode bit zero is interval mode by default; one is watchdog mode.
// R9 - Reset select: zero power-on, one manual; ignored in interval mode.
// R10 - Watchdog overflow flag set only on watchdog-mode overflow.
// R11 - Interval overflow flag set only on interval-mode overflow.
// R12 - Clock select codes pick divide by 32 up to 4096; default 000.
// R13 - Software stops the counter before changing clock select or mode.
// R14 - Watchdog overflow sets flag, raises chosen reset, counter keeps counting.
// R15 - Interval overflow sets flag, requests interrupt, counter keeps counting.
// R16 - Software rewrites counter to zero in watchdog mode before overflow.
// R17 - Standby exit by interrupt starts count; overflow resumes clock, flag stays clear.
// R18 - After stabilisation overflow the counter stops at zero.
// R19 - Frequency control change starts temporary standby; counter runs until overflow.
// R20 - Software clears run bit and sets select and start count beforehand.
// R21 - Software reads counter for zero or one before reload after frequency change.
// R22 - Clock output enable chooses driving system clock or releasing output pin.
// R23 - Clock output enable resets to one; zero releases pin, internals continue.
// R24 - Wrap from FF to 00 is one overflow event.
`timescale 1ns/1ns
`default_nettype none
`include "wit_map.vh"

module wit_top #(
    parameter PRE_W = `WIT_PRE_W
) (
    // Clock and pin reset
    input  wire             clk,
    input  wire             reset_n,
    // Register access
    input  wire             reg_sel,
    input  wire             reg_wr,
    input  wire [31:0]      reg_addr,
    input  wire [1:0]       reg_size,
    input  wire [15:0]      reg_wdata,
    output reg  [7:0]       reg_rdata,
    // Standby and frequency change
    input  wire             standby_active,
    input  wire             standby_wake,
    input  wire             freq_change,
    output reg              clock_resume,
    // Resets and interrupt
    output reg              por_req,
    output reg              manual_req,
    output reg              interval_irq,
    // Clock output pin control
    input  wire             clock_output_enable,
    input  wire             sys_clk_level,
    output wire             clock_output_pin_o,
    output wire             clock_output_pin_oe
);

    localparam ST_IDLE = 3'b001;
    localparam ST_WAIT = 3'b010;
    localparam ST_STAB = 3'b100;

    reg  [7:0] ctrl_q;
    reg  [7:0] ctrl_d;
    reg  [2:0] state_q;
    reg  [2:0] state_d;
    reg        stopped_q;
    reg        stopped_d;

    wire [7:0] count;
    wire       tick;
    wire       overflow;
    wire       word_wr;
    wire       cnt_load;
    wire       ctrl_load;
    wire       stab;
    wire       run;
    wire       wd_mode;
    wire       wd_ovf;
    wire       it_ovf;
    wire       cnt_tick;
    wire       hold_zero;
    wire       ovf_normal;

    // Control fields
    wire       run_bit;
    wire       mode_select_bit;
    wire       reset_select_bit;
    wire [2:0] clock_select_bits;

    // Next values of registered outputs
    wire       resume_d;
    wire       por_d;
    wire       manual_d;
    wire       irq_d;
    wire       byte_rd;
    wire [7:0] rdata_d;

    // Keyed word write to one register
    function keyed_hit;
        input        wr_word;
        input [31:0] addr;
        input [7:0]  key_byte;
        input [31:0] reg_base;
        input [7:0]  reg_key;
        begin
            keyed_hit = wr_word && (addr == reg_base) && (key_byte == reg_key);
        end
    endfunction

    // Byte read data; unmapped addresses read as zero
    function [7:0] read_mux;
        input [31:0] addr;
        input [7:0]  count_val;
        input [7:0]  ctrl_val;
        begin
            case (addr)
                `WIT_ADDR_COUNT: read_mux = count_val;
                `WIT_ADDR_CTRL:  read_mux = ctrl_val;
                default:         read_mux = 8'h00;
            endcase
        end
    endfunction

    // Only keyed word writes reach the registers
    assign word_wr   = reg_sel && reg_wr && (reg_size == `WIT_SIZE_WORD); // R6
    assign cnt_load  = keyed_hit(word_wr, reg_addr, reg_wdata[15:8], `WIT_ADDR_COUNT, `WIT_KEY_COUNT); // R4
    assign ctrl_load = keyed_hit(word_wr, reg_addr, reg_wdata[15:8], `WIT_ADDR_CTRL, `WIT_KEY_CTRL); // R5

    assign run_bit           = ctrl_q[`WIT_BIT_RUN];
    assign mode_select_bit   = ctrl_q[`WIT_BIT_MODE];
    assign reset_select_bit  = ctrl_q[`WIT_BIT_RSEL];
    assign clock_select_bits = ctrl_q[`WIT_SEL_HI:`WIT_SEL_LO];

    assign stab       = (state_q == ST_STAB);
    assign wd_mode    = mode_select_bit; // R8
    // Normal counting gated by run bit, stabilisation counts regardless
    assign run        = (run_bit && !standby_active && state_q == ST_IDLE) || stab; // R7
    assign cnt_tick   = tick && run;
    assign hold_zero  = stopped_q && !run;
    // Stabilisation overflow only resumes clocks: no flag, no reset, no interrupt
    assign ovf_normal = overflow && !stab; // R17
    assign wd_ovf     = ovf_normal && wd_mode;
    assign it_ovf     = ovf_normal && !wd_mode;

    // Event pulses follow the overflow that causes them by one cycle
    assign resume_d = stab && overflow; // R17
    assign por_d    = wd_ovf && !reset_select_bit; // R14
    assign manual_d = wd_ovf && reset_select_bit; // R9
    assign irq_d    = it_ovf; // R15
    assign byte_rd  = reg_sel && !reg_wr && (reg_size == `WIT_SIZE_BYTE);
    assign rdata_d  = read_mux(reg_addr, count, ctrl_q); // R6

    wit_prescaler #(
        .PRE_W             (PRE_W)
    ) u_pre (
        .clk               (clk),
        .reset_n           (reset_n),
        .run               (run),
        .clock_select_bits (clock_select_bits),
        .tick              (tick)
    );

    wit_counter u_cnt (
        .clk               (clk),
        .por_n             (reset_n),
        .tick              (cnt_tick),
        .load              (cnt_load),
        .load_value        (reg_wdata[7:0]),
        .stop_zero         (hold_zero),
        .count_q           (count),
        .overflow          (overflow)
    );

    // Standby and frequency-change stabilisation sequencing
    always @* begin
        state_d   = state_q;
        stopped_d = stopped_q;
        // Any count clears the stop; the stabilisation overflow below sets it again
        if (cnt_tick) begin
            stopped_d = 1'b0;
        end
        case (state_q)
            ST_IDLE: begin
                if (freq_change) begin
                    state_d = ST_STAB; // R19
                end else if (standby_active) begin
                    state_d = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (standby_wake) begin
                    state_d = ST_STAB; // R17
                end else if (!standby_active) begin
                    state_d = ST_IDLE;
                end
            end
            ST_STAB: begin
                if (overflow) begin
                    state_d   = ST_IDLE; // R18
                    stopped_d = 1'b1;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // Control register: flags set by hardware win over a software write
    always @* begin
        ctrl_d = ctrl_q;
        if (ctrl_load) begin
            ctrl_d = reg_wdata[7:0]; // R5
        end
        if (wd_ovf) begin
            ctrl_d[`WIT_BIT_WDOG_FLAG] = 1'b1; // R10
        end
        if (it_ovf) begin
            ctrl_d[`WIT_BIT_INT_FLAG] = 1'b1; // R11
        end
    end

    // Registers clear only on the pin reset; internal resets leave them alone
    always @(posedge clk) begin
        if (!reset_n) begin
            ctrl_q    <= `WIT_RST_CTRL; // R2
            state_q   <= ST_IDLE;
            stopped_q <= 1'b0;
        end else begin
            ctrl_q    <= ctrl_d; // R3
            state_q   <= state_d;
            stopped_q <= stopped_d;
        end
    end

    // Event outputs to reset logic, interrupt controller and clock generator
    always @(posedge clk) begin
        if (!reset_n) begin
            clock_resume <= 1'b0;
            por_req      <= 1'b0;
            manual_req   <= 1'b0;
            interval_irq <= 1'b0;
        end else begin
            clock_resume <= resume_d;
            por_req      <= por_d;
            manual_req   <= manual_d;
            interval_irq <= irq_d;
        end
    end

    // Read data holds until the next byte read
    always @(posedge clk) begin
        if (!reset_n) begin
            reg_rdata <= 8'h00;
        end else if (byte_rd) begin
            reg_rdata <= rdata_d; // R6
        end
    end

    // Pin released (pulled up externally) when output disabled
    assign clock_output_pin_o  = sys_clk_level; // R22
    assign clock_output_pin_oe = clock_output_enable; // R23

endmodule
`default_nettype wire
